// ### design/pwp_consts.svh
// Constants for the write-protect and addressing block: command codes,
// protection codes, field positions and reset values.
// Assumes a PMBus front end that hands over decoded command transactions.
// Function
// RULE_01: Strict code accepts only lock, page, unlock, store-all
// RULE_02: Intermediate code also accepts operation, pointer, mask, clear
// RULE_03: Zero code with pin low accepts everything
// RULE_04: Host writes only the three defined codes; the lock register here takes any byte written, and other values act strict
// RULE_05: Protect pin high means intermediate protection
// RULE_06: Stricter of pin and register wins
// RULE_07: Mask bit n enables channel n globally
// RULE_08: Bus address is base plus pin offset
// RULE_09: Base defaults 0x5C; both pins high give 2
// RULE_10: Base register bit 7 reads zero
// RULE_11: Block data readable as sequential word reads
// RULE_12: Two extra hosts peek with cached page, pointer
// RULE_13: Two extra hosts poke with cached page
// RULE_14: Indirect accesses never disturb primary page
// RULE_15: Global page limits writes, faults other accesses
// RULE_16: Reads succeed at every protection level
// RULE_17: Refused write changes nothing, raises fault
`ifndef PWP_CONSTS_SVH
`define PWP_CONSTS_SVH

// ==========================================================
// Command codes
`define PWP_CMD_PAGE        8'h00
`define PWP_CMD_OPERATION   8'h01
`define PWP_CMD_ON_OFF      8'h02
`define PWP_CMD_CLEAR       8'h03
`define PWP_CMD_LOCK_LEVEL  8'h10
`define PWP_CMD_STORE_ALL   8'h15
`define PWP_CMD_EE_UNLOCK   8'hbd
`define PWP_CMD_IND_PTR     8'hd0
`define PWP_CMD_DATA_A      8'hd1
`define PWP_CMD_DATA_B      8'hd2
`define PWP_CMD_STAT_A      8'hd3
`define PWP_CMD_STAT_B      8'hd4
`define PWP_CMD_GMASK       8'hd5
`define PWP_CMD_BASE_ADDR   8'hd6
`define PWP_PTR_BLOCK       9'h0ee

// ==========================================================
// Protection codes and reset values
`define PWP_LVL_STRICT      8'h80
`define PWP_LVL_MID         8'h40
`define PWP_LVL_NONE        8'h00
`define PWP_PAGE_ALL        8'hff
`define PWP_RST_LOCK        8'h00
`define PWP_RST_GMASK       8'hff
`define PWP_RST_BASE        7'h5c
`define PWP_RST_PAGE        8'h00

// ==========================================================
// Indirect pointer word fields
`define PWP_IP_ID           14
`define PWP_IP_PAGE_HI      13
`define PWP_IP_PAGE_LO      9
`define PWP_IP_PTR_HI       8

`endif

// ### design/pwp_pkg.sv
// Types for the write-protect and addressing block.
// Assumes pwp_consts.svh is compiled alongside.
package pwp_pkg;

  // ==========================================================
  // Transaction carriers
  typedef struct packed {
    logic [6:0]  addr;   // Bus address of the transaction
    logic        wr;     // 1 write, 0 read
    logic [7:0]  code;   // Command code
    logic [15:0] data;   // Write data
  } pwp_req_t;

  typedef struct packed {
    logic        valid;  // One-cycle read request to internal store
    logic [8:0]  ptr;
    logic [7:0]  page;
    logic [8:0]  idx;    // Block byte-pair index
  } pwp_rd_t;

  typedef struct packed {
    logic        valid;  // One-cycle write to internal store
    logic [8:0]  ptr;
    logic [7:0]  chmask; // Channels that take the write
    logic [15:0] data;
  } pwp_wr_t;

  typedef enum logic [1:0] {
    PWP_IDLE  = 2'b01,
    PWP_FETCH = 2'b10
  } pwp_state_t;

endpackage

// ### design/pwp_top.sv
// Command gating, protection, global page mask, bus address and the
// indirect pointer hosts of a PMBus slave.
// Assumes the bus front end delivers one decoded transaction per request
// and that the internal store answers a read in the same cycle as int_rd_q.
`include "pwp_consts.svh"

module pwp_top import pwp_pkg::*; #(
  parameter int BLK_LEN = 256
) (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        wp_pin,
  input  wire logic [1:0]  addr_select_pin_lo,
  input  wire logic [1:0]  addr_select_pin_hi,
  input  wire logic        req_valid,
  input  wire pwp_req_t    req,
  input  wire logic [15:0] int_rdata,
  output logic             req_ready_q,
  output logic [6:0]       dev_addr_q,
  output logic             rsp_valid_q,
  output logic [15:0]      rsp_rdata_q,
  output logic             rsp_cml_q,
  output pwp_rd_t          int_rd_q,
  output pwp_wr_t          int_wr_q
);

  // ==========================================================
  // Helper functions
  function automatic logic [3:0] asel_offset(input logic [1:0] lo, input logic [1:0] hi);
    logic [3:0] l;
    logic [3:0] h;
    logic [3:0] i;
    l = (lo == 2'h3) ? 4'h2 : {2'h0, lo};
    h = (hi == 2'h3) ? 4'h2 : {2'h0, hi};
    i = h * 4'h3 + l;
    return (i >= 4'h6) ? i - 4'h6 : i + 4'h3;
  endfunction

  function automatic logic [7:0] page_onehot(input logic [7:0] pg);
    return (pg < 8'h08) ? 8'h01 << pg[2:0] : 8'h00;
  endfunction

  function automatic logic wr_ok(input logic [7:0] c, input logic strict, input logic mid);
    logic always_ok;
    logic mid_ok;
    always_ok = c == `PWP_CMD_LOCK_LEVEL || c == `PWP_CMD_PAGE ||
                c == `PWP_CMD_EE_UNLOCK  || c == `PWP_CMD_STORE_ALL;
    mid_ok    = c == `PWP_CMD_OPERATION || c == `PWP_CMD_IND_PTR ||
                c == `PWP_CMD_GMASK     || c == `PWP_CMD_CLEAR;
    return always_ok || (!strict && (!mid || mid_ok));
  endfunction

  // ==========================================================
  // State
  pwp_state_t  state_q;
  pwp_req_t    req_q;
  logic [7:0]  lock_q;
  logic [7:0]  page_q;
  logic [7:0]  gmask_q;
  logic [6:0]  base_q;
  logic [14:0] iptr_word_q;
  logic [8:0]  cptr_q  [2];
  logic [4:0]  cpage_q [2];
  logic [8:0]  idx_q   [2];
  logic [1:0]  poke_rej_q;

  // ==========================================================
  // Request intake
  // Ready gates the take too, so nothing is taken on the edge that leaves reset
  wire take      = req_ready_q && state_q == PWP_IDLE && req_valid && req.addr == dev_addr_q; // RULE_08
  wire in_data   = req.code == `PWP_CMD_DATA_A || req.code == `PWP_CMD_DATA_B;
  wire in_host   = req.code == `PWP_CMD_DATA_B;

  // Read address toward the store; indirect hosts use their own cache
  pwp_rd_t rd_d;
  assign rd_d.valid = take && !req.wr;
  assign rd_d.ptr   = in_data ? cptr_q[in_host] : {1'b0, req.code};         // RULE_12
  assign rd_d.page  = in_data ? {3'h0, cpage_q[in_host]} : page_q;          // RULE_14
  assign rd_d.idx   = in_data ? idx_q[in_host] : 9'h000;                    // RULE_11

  // ==========================================================
  // Decode of the captured request
  wire [7:0] c        = req_q.code;
  wire       is_wr    = req_q.wr;
  wire       is_data  = c == `PWP_CMD_DATA_A || c == `PWP_CMD_DATA_B;
  wire       is_stat  = c == `PWP_CMD_STAT_A || c == `PWP_CMD_STAT_B;
  wire       host     = c == `PWP_CMD_DATA_B || c == `PWP_CMD_STAT_B;
  wire       is_local = c == `PWP_CMD_LOCK_LEVEL || c == `PWP_CMD_PAGE || c == `PWP_CMD_GMASK ||
                        c == `PWP_CMD_BASE_ADDR || c == `PWP_CMD_IND_PTR || is_data || is_stat;
  wire       is_paged = !is_local && c != `PWP_CMD_EE_UNLOCK && c != `PWP_CMD_STORE_ALL;
  wire       glob_ok  = c == `PWP_CMD_CLEAR || c == `PWP_CMD_OPERATION || c == `PWP_CMD_ON_OFF;

  // Effective protection: stricter of pin and register; reserved codes act strict
  wire lvl_strict = lock_q != `PWP_LVL_NONE && lock_q != `PWP_LVL_MID;     // RULE_06
  wire lvl_mid    = lock_q == `PWP_LVL_MID || wp_pin;                       // RULE_05
  wire prot_rej   = is_wr && !wr_ok(c, lvl_strict, lvl_mid);                // RULE_01 RULE_02 RULE_03

  // Global page handling and bad page detection
  wire       page_all = page_q == `PWP_PAGE_ALL;
  wire       ff_fault = page_all && is_paged && (!is_wr || !glob_ok);       // RULE_15
  wire [7:0] prim_msk = page_all ? gmask_q : page_onehot(page_q);          // RULE_07
  wire [7:0] poke_msk = page_onehot({3'h0, cpage_q[host]});                 // RULE_13
  wire       bad_page = is_wr && ((is_data && poke_msk == 8'h00) ||
                                  (is_paged && !page_all && prim_msk == 8'h00));
  wire       fault    = prot_rej || ff_fault || bad_page || (is_wr && is_stat); // RULE_17
  wire       wr_go    = state_q == PWP_FETCH && is_wr && !fault;
  wire       rd_go    = state_q == PWP_FETCH && !is_wr;

  // Block reads past the end of the buffer return zeros
  wire blk_ptr  = cptr_q[host] == `PWP_PTR_BLOCK;
  wire blk_end  = idx_q[host] >= 9'(BLK_LEN);                               // RULE_11

  // Forwarded write toward the store
  pwp_wr_t wr_d;
  assign wr_d.valid  = wr_go && (is_data || !is_local);
  assign wr_d.ptr    = is_data ? cptr_q[host] : {1'b0, c};
  assign wr_d.chmask = is_data ? poke_msk : (is_paged ? prim_msk : 8'h00);
  assign wr_d.data   = req_q.data;

  // Read answer; reads are never gated by protection
  logic [15:0] rdata;
  always_comb begin                                                         // RULE_16
    unique case (1'b1)
      c == `PWP_CMD_LOCK_LEVEL: rdata = {8'h00, lock_q};
      c == `PWP_CMD_PAGE:       rdata = {8'h00, page_q};
      c == `PWP_CMD_GMASK:      rdata = {8'h00, gmask_q};
      c == `PWP_CMD_BASE_ADDR:  rdata = {9'h000, base_q};                   // RULE_10
      c == `PWP_CMD_IND_PTR:    rdata = {1'b0, iptr_word_q};
      is_stat:                  rdata = {14'h0000, blk_ptr && blk_end, poke_rej_q[host]};
      is_data:                  rdata = (blk_ptr && blk_end) ? 16'h0000 : int_rdata;
      ff_fault:                 rdata = 16'h0000;
      default:                  rdata = int_rdata;
    endcase
  end

  // ==========================================================
  // Sequencer and answer registers
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q     <= PWP_IDLE;
      req_q       <= '0;
      req_ready_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      rsp_rdata_q <= 16'h0000;
      rsp_cml_q   <= 1'b0;
      int_rd_q    <= '0;
      int_wr_q    <= '0;
    end else begin
      state_q     <= take ? PWP_FETCH : PWP_IDLE;
      req_q       <= take ? req : req_q;
      req_ready_q <= !take;
      rsp_valid_q <= state_q == PWP_FETCH;
      rsp_rdata_q <= rd_go ? rdata : 16'h0000;
      rsp_cml_q   <= state_q == PWP_FETCH && fault;
      int_rd_q    <= rd_d;
      int_wr_q    <= wr_d;
    end
  end

  // Local registers; a refused write leaves them untouched
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      lock_q      <= `PWP_RST_LOCK;
      page_q      <= `PWP_RST_PAGE;
      gmask_q     <= `PWP_RST_GMASK;
      base_q      <= `PWP_RST_BASE;                                         // RULE_09
      iptr_word_q <= 15'h0000;
      dev_addr_q  <= `PWP_RST_BASE;
    end else begin
      if (wr_go && c == `PWP_CMD_LOCK_LEVEL) lock_q <= req_q.data[7:0];     // RULE_17
      if (wr_go && c == `PWP_CMD_PAGE) page_q <= req_q.data[7:0];
      if (wr_go && c == `PWP_CMD_GMASK) gmask_q <= req_q.data[7:0];         // RULE_07
      if (wr_go && c == `PWP_CMD_BASE_ADDR) base_q <= req_q.data[6:0];      // RULE_10
      if (wr_go && c == `PWP_CMD_IND_PTR) iptr_word_q <= req_q.data[14:0];
      dev_addr_q <= base_q + {3'h0, asel_offset(addr_select_pin_lo, addr_select_pin_hi)}; // RULE_08 RULE_09
    end
  end

  // ==========================================================
  // Per-host cached pointer, page, block index and poke status
  for (genvar h = 0; h < 2; h++) begin : g_host
    wire sel     = req_q.data[`PWP_IP_ID] == 1'(h);
    wire set_ptr = wr_go && c == `PWP_CMD_IND_PTR && sel;
    wire mine    = host == 1'(h);
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        cptr_q[h]     <= 9'h000;
        cpage_q[h]    <= 5'h00;
        idx_q[h]      <= 9'h000;
        poke_rej_q[h] <= 1'b0;
      end else begin
        if (set_ptr) begin                                                  // RULE_12 RULE_13
          cptr_q[h]  <= req_q.data[`PWP_IP_PTR_HI:0];
          cpage_q[h] <= req_q.data[`PWP_IP_PAGE_HI:`PWP_IP_PAGE_LO];
          idx_q[h]   <= 9'h000;
        end else if (rd_go && is_data && mine && blk_ptr && !blk_end) begin
          idx_q[h] <= idx_q[h] + 9'h001;                                    // RULE_11
        end
        if (state_q == PWP_FETCH && is_wr && is_data && mine && fault) begin
          poke_rej_q[h] <= 1'b1;
        end else if (set_ptr) begin
          poke_rej_q[h] <= 1'b0;
        end
      end
    end
  end

endmodule // pwp_top

// ### verification/pwp_checker.sv
// Port-level assertions for pwp_top.
// Bound into every pwp_top instance; sees only its ports.
`include "pwp_consts.svh"
module pwp_checker import pwp_pkg::*; #(
  parameter int BLK_LEN = 256
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        wp_pin,
  input wire logic        req_valid,
  input wire pwp_req_t    req,
  input wire logic        req_ready_q,
  input wire logic [6:0]  dev_addr_q,
  input wire logic        rsp_valid_q,
  input wire logic [15:0] rsp_rdata_q,
  input wire logic        rsp_cml_q,
  input wire pwp_rd_t     int_rd_q,
  input wire pwp_wr_t     int_wr_q
);
  timeunit 1ns;
  timeprecision 100ps;
  // ======
  // Take decode and properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire take   = req_valid && req_ready_q && req.addr == dev_addr_q;
  wire take_w = take && req.wr;
  wire take_r = take && !req.wr;
  property p_answer; take |-> ##2 rsp_valid_q; endproperty
  property p_stray; rsp_valid_q |-> $past(take, 2); endproperty
  property p_busy; take |=> !req_ready_q ##1 req_ready_q; endproperty
  property p_rd_cause; int_rd_q.valid |-> $past(take_r); endproperty
  property p_wr_ok; int_wr_q.valid |-> rsp_valid_q && !rsp_cml_q; endproperty
  property p_lock_ok; take_w && req.code == `PWP_CMD_LOCK_LEVEL |-> ##2 !rsp_cml_q; endproperty
  property p_base_b7; take_r && req.code == `PWP_CMD_BASE_ADDR |-> ##2 rsp_rdata_q[15:7] == 9'h000; endproperty
  property p_pin_poke; take_w && wp_pin && $past(wp_pin) && req.code == `PWP_CMD_DATA_A |-> ##2 rsp_cml_q; endproperty
  property p_pin_onoff;
    take_w && wp_pin && $past(wp_pin) && req.code == `PWP_CMD_ON_OFF |-> ##2 rsp_cml_q && !int_wr_q.valid;
  endproperty
  a_answer: assert property (p_answer)
    else $error("no answer two cycles after take");
  a_stray: assert property (p_stray)
    else $error("answer without a take");
  a_busy: assert property (p_busy)
    else $error("ready not low for one cycle after a take");
  a_rd_cause: assert property (p_rd_cause)
    else $error("store read without a read take");
  a_wr_ok: assert property (p_wr_ok)
    else $error("store write on a refused answer");
  a_lock_ok: assert property (p_lock_ok)
    else $error("lock level write refused");
  a_base_b7: assert property (p_base_b7)
    else $error("base address upper bits not zero");
  a_pin_poke: assert property (p_pin_poke)
    else $error("poke taken with protect pin high");
  a_pin_onoff: assert property (p_pin_onoff)
    else $error("on-off write taken with protect pin high");
  c_poke: cover property (int_wr_q.valid && int_wr_q.data == 16'h1234);
  c_refuse: cover property (rsp_cml_q);
  c_block: cover property (int_rd_q.valid && int_rd_q.ptr == `PWP_PTR_BLOCK);
endmodule // pwp_checker

bind pwp_top pwp_checker #(.BLK_LEN(BLK_LEN)) u_chk (.core_clk, .rst, .wp_pin, .req_valid, .req, .req_ready_q,
  .dev_addr_q, .rsp_valid_q, .rsp_rdata_q, .rsp_cml_q, .int_rd_q, .int_wr_q);

// ### verification/pwp_store_model.sv
// Internal store stand-in answering pwp_top read strobes.
// Assumes the block takes the data in the strobe cycle itself.
`include "pwp_consts.svh"
module pwp_store_model import pwp_pkg::*; (
  input  wire logic    core_clk,
  input  wire pwp_rd_t int_rd_q,
  output logic [15:0]  int_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // ======
  // Read answer
  logic [15:0] junk_q = 16'ha5c3;
  wire         blk    = int_rd_q.ptr == `PWP_PTR_BLOCK;
  // Outside a strobe the data churns so stale values cannot pass
  always @(posedge core_clk) junk_q <= ~junk_q;
  // Word from pointer and page; the block buffer adds its index
  assign int_rdata = int_rd_q.valid ? {int_rd_q.ptr[7:0], int_rd_q.page[3:0], blk ? int_rd_q.idx[3:0] : 4'h0}
                                    : junk_q;
endmodule // pwp_store_model

// ### verification/pmbus_write_protect_addressing_bench.sv
// Self-checking bench for pwp_top with the store model beside it.
// Assumes package, checker and model are compiled first.
`include "pwp_consts.svh"
module pmbus_write_protect_addressing_bench import pwp_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ======
  // Signals and instances
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        wp_pin   = 1'b0;
  logic [1:0]  asl      = 2'h2;
  logic [1:0]  ash      = 2'h2;
  logic        req_valid = 1'b0;
  pwp_req_t    req      = '0;
  logic [15:0] int_rdata, rsp_rdata_q, got_rd;
  logic        req_ready_q, rsp_valid_q, rsp_cml_q, got_v, got_cml;
  logic [6:0]  dev_addr_q;
  logic [6:0]  da       = 7'h5e;
  pwp_rd_t     int_rd_q;
  pwp_wr_t     int_wr_q, got_w;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  pwp_top #(.BLK_LEN(4)) dut (.core_clk, .rst, .wp_pin, .addr_select_pin_lo(asl), .addr_select_pin_hi(ash),
    .req_valid, .req, .int_rdata, .req_ready_q, .dev_addr_q, .rsp_valid_q, .rsp_rdata_q, .rsp_cml_q, .int_rd_q,
    .int_wr_q);
  pwp_store_model store (.core_clk, .int_rd_q, .int_rdata);
  // Clock and hang guard
  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      print_verdict();
    end
  end
  // ======
  // Shared tasks
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic xfer(input logic [6:0] a, input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge core_clk);
    #1;
    req_valid = 1'b1;
    req = '{a, w, c, d};
    repeat (2) begin
      @(posedge core_clk);
      #1;
      req_valid = 1'b0;
    end
    got_v = rsp_valid_q;
    got_cml = rsp_cml_q;
    got_rd = rsp_rdata_q;
    got_w = int_wr_q;
  endtask
  task automatic wrx(input logic [7:0] c, input logic [15:0] d, input logic ecml);
    xfer(da, 1'b1, c, d);
    chk("write answer", {14'h0, 1'b1, ecml}, {14'h0, got_v, got_cml});
  endtask
  task automatic rdx(input logic [7:0] c, input logic [15:0] exp);
    xfer(da, 1'b0, c, 16'h0000);
    chk("read answer", 16'h0002, {14'h0, got_v, got_cml});
    chk("read data", exp, got_rd);
  endtask
  task automatic pins(input logic wp, input logic [1:0] lo, input logic [1:0] hi);
    @(posedge core_clk);
    #1;
    wp_pin = wp;
    asl = lo;
    ash = hi;
  endtask
  // ======
  // Scenarios
  task automatic t_reset;
    repeat (2) @(posedge core_clk);
    #1;
    chk("address", 16'h005e, {9'h0, dev_addr_q});
    rdx(`PWP_CMD_LOCK_LEVEL, 16'h0000);
    rdx(`PWP_CMD_GMASK, 16'h00ff);
    rdx(`PWP_CMD_BASE_ADDR, 16'h005c);
    xfer(7'h5c, 1'b0, `PWP_CMD_PAGE, 16'h0000);
    chk("stray answer", 16'h0000, {15'h0, got_v});
    $display("t_reset done");
  endtask
  task automatic t_levels;
    logic [7:0] lv;
    logic       strict, none;
    for (int i = 0; i < 6; i++) begin
      lv = (i % 3 == 0) ? 8'h00 : (i % 3 == 1) ? 8'h40 : 8'h80;
      strict = lv == 8'h80;
      none = lv == 8'h00 && i < 3;
      pins(i >= 3, asl, ash);
      wrx(`PWP_CMD_LOCK_LEVEL, {8'h0, lv}, 1'b0);
      wrx(`PWP_CMD_OPERATION, 16'h0080, strict);
      wrx(`PWP_CMD_GMASK, 16'h00ff, strict);
      wrx(`PWP_CMD_ON_OFF, 16'h001e, !none);
      wrx(`PWP_CMD_PAGE, 16'h0000, 1'b0);
      rdx(`PWP_CMD_LOCK_LEVEL, {8'h0, lv});
    end
    pins(1'b0, asl, ash);
    wrx(`PWP_CMD_LOCK_LEVEL, 16'h0000, 1'b0);
    $display("t_levels done");
  endtask
  task automatic t_gmask;
    wrx(`PWP_CMD_GMASK, 16'h0005, 1'b0);
    wrx(`PWP_CMD_PAGE, 16'h00ff, 1'b0);
    wrx(`PWP_CMD_OPERATION, 16'h0080, 1'b0);
    chk("global mask", 16'h0005, {8'h0, got_w.chmask});
    wrx(8'h21, 16'h1000, 1'b1);
    wrx(`PWP_CMD_PAGE, 16'h0003, 1'b0);
    wrx(`PWP_CMD_OPERATION, 16'h0080, 1'b0);
    chk("page mask", 16'h0008, {8'h0, got_w.chmask});
    $display("t_gmask done");
  endtask
  task automatic t_base;
    wrx(`PWP_CMD_BASE_ADDR, 16'h0090, 1'b0);
    da = 7'h12;
    rdx(`PWP_CMD_BASE_ADDR, 16'h0010);
    pins(1'b0, 2'h0, 2'h0);
    @(posedge core_clk);
    #1;
    da = 7'h13;
    chk("address", {9'h0, da}, {9'h0, dev_addr_q});
    rdx(`PWP_CMD_LOCK_LEVEL, 16'h0000);
    $display("t_base done");
  endtask
  task automatic t_block;
    wrx(`PWP_CMD_IND_PTR, 16'h00ee, 1'b0);
    for (int k = 0; k < 5; k++)
      rdx(`PWP_CMD_DATA_A, (k < 4) ? {8'hee, 4'h0, 4'(k)} : 16'h0000);
    rdx(`PWP_CMD_STAT_A, 16'h0002);
    wrx(`PWP_CMD_IND_PTR, 16'h4601, 1'b0);
    rdx(`PWP_CMD_DATA_B, 16'h0130);
    rdx(`PWP_CMD_PAGE, 16'h0003);
    $display("t_block done");
  endtask
  task automatic t_poke;
    wrx(`PWP_CMD_IND_PTR, 16'h0401, 1'b0);
    wrx(`PWP_CMD_DATA_A, 16'h1234, 1'b0);
    chk("poke data", 16'h1234, got_w.data);
    chk("poke mask", 16'h0004, {8'h0, got_w.chmask});
    pins(1'b1, asl, ash);
    wrx(`PWP_CMD_DATA_A, 16'h5678, 1'b1);
    rdx(`PWP_CMD_STAT_A, 16'h0001);
    pins(1'b0, asl, ash);
    wrx(`PWP_CMD_IND_PTR, 16'h1001, 1'b0);
    wrx(`PWP_CMD_DATA_A, 16'h0001, 1'b1);
    $display("t_poke done");
  endtask
  // ======
  // Verdict and main sequence
  task automatic print_verdict;
    $display("checks_done %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_levels();
    t_gmask();
    t_base();
    t_block();
    t_poke();
    print_verdict();
  end
endmodule // pmbus_write_protect_addressing_bench
